// *** verilog/swc_top.sv ***
/*
 what the file holds: the power-down control: system control register, power state machine,
 clock gating and wake sequencing.
 what it assumes: an APB master; the cpu pulses sleep_req when it runs the sleep
 instruction; the interrupt inputs are synchronous to pclk.
*/
// Decided for this implementation: register access over APB.
module swc_top (
   // apb clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // cpu side
   input wire logic sleep_req,
   output logic cpu_hold,
   output logic cpu_regs_keep,
   output logic nmi_take,
   // external interrupts
   input wire logic nmi_pin,
   input wire logic [2:0] irq_pin,
   // power control outputs
   output logic periph_clk_en,
   output logic osc_stop,
   output logic periph_reset,
   output logic ram_enable_bit
);
   // all state of the block
   typedef struct packed {
      logic [7:0] sysctl;            // system control register
      swc_pkg::swc_state_t state;    // power state
      logic [31:0] rdata;            // read data
      logic nmi_pend;                // nmi exception due
      logic wake_irq;                // wake came from an irq line
   } swc_st_t;

   swc_st_t st_r;   // registered state
   swc_st_t st_nxt; // next state

   logic nmi_edge;   // selected nmi edge seen
   logic tmr_done;   // wake delay expired
   logic tmr_start;  // start wake delay
   logic tmr_clear;  // clear wake delay
   logic acc;        // apb access phase
   logic hit_ctl;    // address is system control
   logic hit_sts;    // address is status

   // address decode, used for both reads and writes
   function automatic logic addr_is(input logic [15:0] a, input logic [15:0] target);
      addr_is = (a == target);
   endfunction

   // wake edge detector
   swc_edge_detect u_edge (
      .pclk(pclk),
      .presetn(presetn),
      .pin(nmi_pin),
      .rising_sel(st_r.sysctl[swc_pkg::EDGE_SEL_POS]),
      .edge_pulse(nmi_edge)
   );

   // standby timer
   swc_wake_timer #(.W(swc_pkg::DLY_W)) u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .clear(tmr_clear),
      .start(tmr_start),
      .sts(st_r.sysctl[swc_pkg::STS_HI_POS:swc_pkg::STS_LO_POS]),
      .done(tmr_done)
   );

   // decode
   assign acc = psel && penable;
   assign hit_ctl = addr_is(paddr, swc_pkg::SYSCTL_ADDR);
   assign hit_sts = addr_is(paddr, swc_pkg::STATUS_ADDR);

   // timer control from the state machine
   assign tmr_clear = (st_r.state == swc_pkg::SWC_RUN) && sleep_req;
   // only external interrupts start the wake; an nmi edge or any high irq line starts the timer
   assign tmr_start = (st_r.state == swc_pkg::SWC_HARDWARE_STANDBY_PIN) && (nmi_edge || (|irq_pin));

   // next state logic
   always_comb begin
      st_nxt = st_r;
      // register write, lane 0 only
      if (acc && pwrite && hit_ctl && pstrb[0]) begin
         // edge select and ram enable are plain writable bits
         st_nxt.sysctl = (pwdata[7:0] & swc_pkg::SYSCTL_WMASK) | swc_pkg::SYSCTL_FIXED;
      end
      // read data path
      if (psel && !penable && !pwrite) begin
         if (hit_ctl) begin
            st_nxt.rdata = {24'h000000, st_r.sysctl};
         end else if (hit_sts) begin
            st_nxt.rdata = {27'h0000000, st_r.nmi_pend, st_r.state};
         end else begin
            st_nxt.rdata = 32'h00000000;
         end
      end
      // nmi exception taken by the cpu in one cycle
      if (st_r.nmi_pend) begin
         st_nxt.nmi_pend = 1'b0;
      end
      // power state machine
      unique case (st_r.state)
         swc_pkg::SWC_RUN: begin
            if (nmi_edge) begin
               st_nxt.nmi_pend = 1'b1;
            end
            if (sleep_req) begin
               st_nxt.state = st_r.sysctl[swc_pkg::SOFTWARE_STANDBY_SELECT_POS] ? swc_pkg::SWC_HARDWARE_STANDBY_PIN
                                                              : swc_pkg::SWC_SLEEP;
            end
         end
         swc_pkg::SWC_SLEEP: begin
            // any interrupt wakes from sleep; peripherals still run
            if (nmi_edge || (|irq_pin)) begin
               st_nxt.state = swc_pkg::SWC_RUN;
               st_nxt.nmi_pend = nmi_edge;
            end
         end
         swc_pkg::SWC_HARDWARE_STANDBY_PIN: begin
            if (tmr_start) begin
               st_nxt.state = swc_pkg::SWC_WAKE;
               st_nxt.wake_irq = !nmi_edge;
            end
         end
         swc_pkg::SWC_WAKE: begin
            if (tmr_done) begin
               st_nxt.state = swc_pkg::SWC_RUN;
               st_nxt.nmi_pend = !st_r.wake_irq;
               st_nxt.wake_irq = 1'b0;
            end
         end
         default: begin
            st_nxt.state = swc_pkg::SWC_RUN;
         end
      endcase
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r.sysctl <= swc_pkg::SYSCTL_RESET;
         st_r.state <= swc_pkg::SWC_RUN;
         st_r.rdata <= 32'h00000000;
         st_r.nmi_pend <= 1'b0;
         st_r.wake_irq <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // apb answers: no wait states; read data is loaded from a flop during the setup phase
   assign pready = 1'b1;
   assign pslverr = acc && !(hit_ctl || hit_sts);
   assign prdata = st_r.rdata;

   // cpu held in every low-power state
   assign cpu_hold = (st_r.state != swc_pkg::SWC_RUN);
   // register file kept in sleep and standby
   assign cpu_regs_keep = cpu_hold;
   assign nmi_take = st_r.nmi_pend;
   // gate the internal clock to peripherals in standby and wake delay
   assign periph_clk_en = (st_r.state == swc_pkg::SWC_RUN) ||
                          (st_r.state == swc_pkg::SWC_SLEEP);
   assign osc_stop = (st_r.state == swc_pkg::SWC_HARDWARE_STANDBY_PIN);
   // peripherals held in reset through standby and wake
   assign periph_reset = !periph_clk_en;
   assign ram_enable_bit = st_r.sysctl[swc_pkg::RAM_ENABLE_POS];
endmodule

// *** verilog/swc_pkg.sv ***
/*
 what the file holds: constants and types shared by the standby and wake control block.
 what it assumes: a 50 MHz pclk, and APB with 32-bit data.
*/
package swc_pkg;
   // register map: the printed offset is a multiple of four, so it is the byte address
   localparam logic [15:0] SYSCTL_ADDR = 16'hFFC4;  // system control register
   localparam logic [15:0] STATUS_ADDR = 16'hFFC8;  // power state readback
   // system control field positions
   localparam int RAM_ENABLE_POS = 0;  // on-chip ram enable
   localparam int EDGE_SEL_POS = 2;    // interrupt edge select, 1 = rising
   localparam int STS_LO_POS = 4;      // standby timer select, low bit
   localparam int STS_HI_POS = 6;      // standby timer select, high bit
   localparam int SOFTWARE_STANDBY_SELECT_POS = 7;        // software standby select
   // reset value: edge select falling, ram enabled
   localparam logic [7:0] SYSCTL_RESET = 8'h09;
   // bits that software may write; bit 3 reads as one, bit 1 reads as zero
   localparam logic [7:0] SYSCTL_WMASK = 8'hF5;
   localparam logic [7:0] SYSCTL_FIXED = 8'h08;
   // standby timer select codes
   localparam logic [2:0] STS_8K = 3'h0;
   localparam logic [2:0] STS_16K = 3'h1;
   localparam logic [2:0] STS_32K = 3'h2;
   localparam logic [2:0] STS_64K = 3'h3;
   // wake delays in clock cycles
   localparam logic [17:0] DLY_8K = 18'h02000;
   localparam logic [17:0] DLY_16K = 18'h04000;
   localparam logic [17:0] DLY_32K = 18'h08000;
   localparam logic [17:0] DLY_64K = 18'h10000;
   localparam logic [17:0] DLY_128K = 18'h20000;
   localparam int DLY_W = 18;  // width of the wake delay count

   // power states, one-hot
   typedef enum logic [3:0] {
      SWC_RUN = 4'h1,    // normal operation
      SWC_SLEEP = 4'h2,  // cpu halted, peripherals clocked
      SWC_HARDWARE_STANDBY_PIN = 4'h4,   // software standby, oscillator stopped
      SWC_WAKE = 4'h8    // standby timer running
   } swc_state_t;
endpackage

// *** verilog/swc_edge_detect.sv ***
/*
 what the file holds: edge detector for the non-maskable interrupt input.
 what it assumes: the input is synchronous to pclk.
*/
module swc_edge_detect (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // pin and selection
   input wire logic pin,
   input wire logic rising_sel,
   // detected edge
   output logic edge_pulse
);
   // held state of the detector
   typedef struct packed {
      logic prev;  // pin one cycle ago
   } swc_ed_t;

   swc_ed_t st_r;   // registered state
   swc_ed_t st_nxt; // next state

   // next state logic
   always_comb begin
      st_nxt = st_r;
      st_nxt.prev = pin;
   end

   // state register; pin assumed idle high at reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '{prev: 1'b1};
      end else begin
         st_r <= st_nxt;
      end
   end

   // pick the selected edge
   assign edge_pulse = rising_sel ? (pin & ~st_r.prev) : (~pin & st_r.prev);
endmodule

// *** verilog/swc_wake_timer.sv ***
/*
 what the file holds: the standby timer that delays resumption after an nmi wake edge or a high irq line.
 what it assumes: start and clear come from the power state machine.
*/
module swc_wake_timer #(
   parameter int W = swc_pkg::DLY_W  // counter width
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // control
   input wire logic clear,
   input wire logic start,
   input wire logic [2:0] sts,
   // status
   output logic done
);
   // refuse a counter that cannot hold the longest wake delay
   if (W < swc_pkg::DLY_W) begin : g_width_bad
      $error("swc_wake_timer: counter too narrow");
   end

   // held state of the timer
   typedef struct packed {
      logic run;       // counting
      logic [W-1:0] cnt; // cycles elapsed
      logic [W-1:0] lim; // selected delay
   } swc_wt_t;

   swc_wt_t st_r;   // registered state
   swc_wt_t st_nxt; // next state

   // delay chosen by the select code
   function automatic logic [W-1:0] sts_delay(input logic [2:0] code);
      if (code[2]) begin
         sts_delay = W'(swc_pkg::DLY_128K);
      end else begin
         unique case (code)
            swc_pkg::STS_8K: sts_delay = W'(swc_pkg::DLY_8K);
            swc_pkg::STS_16K: sts_delay = W'(swc_pkg::DLY_16K);
            swc_pkg::STS_32K: sts_delay = W'(swc_pkg::DLY_32K);
            default: sts_delay = W'(swc_pkg::DLY_64K);
         endcase
      end
   endfunction

   // next state logic
   always_comb begin
      st_nxt = st_r;
      if (clear) begin
         st_nxt.run = 1'b0;
         st_nxt.cnt = '0;
      end else if (start) begin
         st_nxt.run = 1'b1;
         st_nxt.cnt = '0;
         st_nxt.lim = sts_delay(sts);
      end else if (st_r.run && (st_r.cnt != st_r.lim)) begin
         st_nxt.cnt = st_r.cnt + W'(1);
      end
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // expiry flag
   assign done = st_r.run && (st_r.cnt == st_r.lim);
endmodule

// *** verif/swc_top_asserts.sv ***
/* checker for the standby and wake control ports.
 assumes: bound to swc_top, everything on pclk. */
module swc_top_asserts (
   // apb side
   input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata, prdata,
   input wire logic [3:0] pstrb,
   // cpu, pins, power
   input wire logic sleep_req, cpu_hold, cpu_regs_keep, nmi_take, nmi_pin,
   input wire logic [2:0] irq_pin,
   input wire logic periph_clk_en, osc_stop, periph_reset, ram_enable_bit
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // write access to the control word with the low byte enabled
   sequence ctl_wr;
      psel && penable && pwrite && paddr == 16'hFFC4 && pstrb[0];
   endsequence
   // sleep taken while running
   sequence sleep_go;
      sleep_req && !cpu_hold;
   endsequence
   chk_ram_bit: assert property (ctl_wr |=> ram_enable_bit == $past(pwdata[0]))
      else $error("ram enable bit not written");
   chk_osc_gate: assert property (osc_stop |-> !periph_clk_en && periph_reset)
      else $error("peripherals clocked in standby");
   chk_regs_keep: assert property (cpu_regs_keep == cpu_hold)
      else $error("cpu register keep differs from hold");
   chk_sleep_hold: assert property (sleep_go |=> cpu_hold)
      else $error("sleep not taken");
   chk_sleep_clk: assert property (cpu_hold && !osc_stop && !periph_reset |-> periph_clk_en)
      else $error("sleep stopped peripheral clock");
   chk_wake_hold: assert property ($fell(osc_stop) |-> cpu_hold [*8])
      else $error("cpu released early after wake");
   chk_irq_wake: assert property (osc_stop && |irq_pin |=> !osc_stop)
      else $error("irq did not leave standby");
   chk_take_once: assert property (nmi_take |=> !nmi_take)
      else $error("nmi take longer than one cycle");
endmodule

bind swc_top swc_top_asserts u_swc_top_asserts (.pclk, .presetn, .psel, .penable, .pwrite,
   .pready, .pslverr, .paddr, .pwdata, .prdata, .pstrb, .sleep_req, .cpu_hold, .cpu_regs_keep,
   .nmi_take, .nmi_pin, .irq_pin, .periph_clk_en, .osc_stop, .periph_reset, .ram_enable_bit);

// *** verif/swc_nmi_src.sv ***
/* model of the source driving the interrupt pin.
 assumes: bench calls set_level right after a rising edge. */
module swc_nmi_src (
   // clock
   input wire logic pclk,
   // driven pin
   output logic nmi_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   initial nmi_pin = 1'b1;  // pin idles high
   // move the pin just after a rising edge and hold it there
   task automatic set_level(input logic v);
      @(posedge pclk);
      nmi_pin <= v;
   endtask
endmodule

// *** verif/testbench.sv ***
/* self-checking bench for swc_top.
 assumes: swc_pkg, checker and pin source compiled first. */
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sleep_req = 0;
   logic [15:0] paddr = 16'h0000;
   logic [31:0] pwdata = 32'h0, prdata, w, exp_q[$], msk_q[$];
   logic [31:0] seed = 32'h0001440E;  // xorshift start 82958
   logic [3:0] pstrb = 4'h1;
   logic [2:0] irq_pin = 3'h0;
   logic pready, pslverr, cpu_hold, cpu_regs_keep, nmi_take, nmi_pin;
   logic periph_clk_en, osc_stop, periph_reset, ram_enable_bit;
   int err_count = 0, num_checks = 0, cyc = 0, n;
   always #10 pclk = ~pclk;
   swc_top u_swc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
      .prdata, .pready, .pslverr, .sleep_req, .cpu_hold, .cpu_regs_keep, .nmi_take,
      .nmi_pin, .irq_pin, .periph_clk_en, .osc_stop, .periph_reset, .ram_enable_bit);
   swc_nmi_src u_swc_nmi_src (.pclk, .nmi_pin);
   // one compare for every result
   task automatic chk(input logic [31:0] got, exp, input string what);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // apb transfer, entered just after a rising edge
   task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // read with the expected value noted for the monitor
   task automatic rd(input logic [15:0] a, input logic [31:0] e, input logic [31:0] m = '1);
      exp_q.push_back(e);
      msk_q.push_back(m);
      apb(1'b0, a, 32'h0);
   endtask
   // write control, then pulse sleep
   task automatic go_sleep(input logic [31:0] ctl);
      apb(1'b1, 16'hFFC4, ctl);
      sleep_req <= 1'b1;
      @(posedge pclk);
      sleep_req <= 1'b0;
      @(posedge pclk);
   endtask
   // count cycles until the cpu is let go
   task automatic wake_chk(input int dly);
      n = 0;
      while (cpu_hold === 1'b1 && n < dly + 9) begin
         @(posedge pclk);
         n++;
      end
      chk(32'(n >= dly && n <= dly + 8), 32'h1, "wake delay");
   endtask
   task automatic complete_run();
      $display("mismatches %0d checks %0d", err_count, num_checks);
      if (err_count == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // read monitor takes the oldest note
   always @(posedge pclk) begin
      if (psel && penable && !pwrite && exp_q.size() > 0) begin
         chk(prdata & msk_q.pop_front(), exp_q.pop_front(), "read");
         chk({31'h0, pslverr}, 32'(paddr != 16'hFFC4 && paddr != 16'hFFC8), "slave error");
      end
   end
   // hang guard
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 95000) begin
         err_count++;
         $display("MISMATCH t=%0t timeout", $time);
         complete_run();
      end
   end
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(16'hFFC4, 32'h09);
      rd(16'hFFC8, 32'h01, 32'h0F);
      rd(16'hFF00, 32'h00);
      for (int i = 0; i < 4; i++) begin
         w = rnd();
         apb(1'b1, 16'hFFC4, w);
         rd(16'hFFC4, {24'h0, w[7:0] & 8'hF5 | 8'h08});
      end
      apb(1'b1, 16'hFFC4, 32'hB9);
      u_swc_nmi_src.set_level(1'b0);
      n = 0;
      repeat (4) begin
         @(posedge pclk);
         n += nmi_take;
      end
      chk(32'(n), 32'h1, "nmi on falling edge");
      go_sleep(32'hBC);
      chk({31'h0, ram_enable_bit}, 32'h0, "ram off");
      rd(16'hFFC8, 32'h04, 32'h0F);
      u_swc_nmi_src.set_level(1'b1);
      wake_chk(65536);
      apb(1'b1, 16'hFFC4, 32'hB9);
      go_sleep(32'h8C);
      u_swc_nmi_src.set_level(1'b0);
      repeat (20) @(posedge pclk);
      rd(16'hFFC8, 32'h04, 32'h0F);
      u_swc_nmi_src.set_level(1'b1);
      wake_chk(8192);
      go_sleep(32'h8D);
      irq_pin <= 3'h2;
      @(posedge pclk);
      irq_pin <= 3'h0;
      wake_chk(8192);
      go_sleep(32'h09);
      rd(16'hFFC8, 32'h02, 32'h0F);
      irq_pin <= 3'h4;
      @(posedge pclk);
      irq_pin <= 3'h0;
      wake_chk(0);
      rd(16'hFFC8, 32'h01, 32'h0F);
      complete_run();
   end
endmodule
